// ### design/vbsu_lane_ops.sv
`timescale 1ns/1ps
`default_nettype none
`include "vbsu_params.svh"

module vbsu_lane_ops
  import vbsu_pkg::*;
(
  // Format and position source.
  input  wire vbsu_fmt_t    fmt,
  input  wire logic         useImmPos,
  input  wire logic [5:0]   immPos,
  // Operand vectors.
  input  wire logic [127:0] firstSrc,
  input  wire logic [127:0] posTest,
  // Per-format results, already selected by fmt.
  output logic      [127:0] bitSetVec,
  output logic      [127:0] cmpEqVec,
  output logic              anyElemZero
);

  logic [3:0][127:0] setByFmt;
  logic [3:0][127:0] eqByFmt;
  logic [3:0]        zeroByFmt;

  // One lane array per element width; element e sits at bits EW*e upward.
  for (genvar f = 0; f < 4; f++) begin : g_fmt
    localparam int EW = 8 << f;
    localparam int LG = 3 + f;
    localparam int NE = `VBSU_VEC_W / EW;
    logic [NE-1:0] elemZero;
    for (genvar e = 0; e < NE; e++) begin : g_el
      logic [LG-1:0] pos;
      logic [EW-1:0] one;
      // Only the low LG bits of the position count, so the shift wraps modulo EW.
      assign pos = useImmPos ? immPos[LG-1:0] : posTest[e*EW +: LG]; // RULE_15
      assign one = {{(EW-1){1'b0}}, 1'b1};
      assign setByFmt[f][e*EW +: EW] = firstSrc[e*EW +: EW] | (one << pos); // RULE_07
      assign eqByFmt[f][e*EW +: EW] =
        {EW{firstSrc[e*EW +: EW] == posTest[e*EW +: EW]}}; // RULE_11
      assign elemZero[e] = ~|posTest[e*EW +: EW];
    end
    assign zeroByFmt[f] = |elemZero; // RULE_09
  end

  // Format select; the 2-bit code indexes the width table directly.
  assign bitSetVec   = setByFmt[fmt]; // RULE_14
  assign cmpEqVec    = eqByFmt[fmt];
  assign anyElemZero = zeroByFmt[fmt];

endmodule : vbsu_lane_ops
`default_nettype wire

// ### design/vbsu_unit.sv
// How it works
// RULE_01 - The whole-vector nonzero branch is taken when any bit of the tested vector is one.
// RULE_02 - The branch offset counts signed instruction words from the delay-slot address.
// RULE_03 - The target offset is offset bit 9 sign-extended over bits 9..0 and two zeros.
// RULE_04 - Software keeps branches and jumps out of a vector branch's delay slot.
// RULE_05 - Register bit select takes first source where old dest is 0, second where 1.
// RULE_06 - Immediate bit select takes the source where old dest is 0, the byte immediate where 1.
// RULE_07 - Register bit set sets in each element the bit named by the position element mod width.
// RULE_08 - Immediate bit set sets in every element the bit named by the 7-bit format/position field.
// RULE_09 - The per-format zero branch is taken when at least one element of that width is zero.
// RULE_10 - The whole-vector zero branch is taken only when every bit of the tested vector is zero.
// RULE_11 - Compare-equal writes all ones per element when the sources match, zeros otherwise.
// RULE_12 - Bit set and compare raise no exception that depends on operand values.
// RULE_13 - Branches and bit selects raise only reserved-instruction or unit-disabled exceptions.
// RULE_14 - The 2-bit format field picks 8, 16, 32 or 64 bit elements laid out from bit 0 upward.
// RULE_15 - The bit position uses 3, 4, 5 or 6 low bits for the four widths; higher bits ignored.
`timescale 1ns/1ps
`default_nettype none
`include "vbsu_params.svh"

module vbsu_unit
  import vbsu_pkg::*;
(
  // Clock and reset.
  input  wire logic           clk,
  input  wire logic           rstn,
  // Decoded issue from the host pipeline.
  input  wire vbsu_issue_t    issueIn,
  // Operand vectors.
  input  wire vbsu_operands_t opsIn,
  // Registered answer, one cycle after issue.
  output var  vbsu_result_t   resultOut
);

  // Classifies an instruction word; anything not of this unit is VBSU_K_NONE.
  // Foreign words under the same major opcodes fall through to none, not reserved,
  // because a neighbouring unit owns them and must not see a spurious fault here.
  function automatic vbsu_kind_t decodeKind(input logic [31:0] w);
    logic [5:0] maj;
    logic [5:0] minor;
    logic [4:0] op5;
    logic [2:0] op3;
    logic [1:0] op2;
    vbsu_kind_t k;
    maj   = w[`VBSU_MAJ_HI:`VBSU_MAJ_LO];
    minor = w[`VBSU_MIN_HI:`VBSU_MIN_LO];
    op5   = w[`VBSU_OP5_HI:`VBSU_OP5_LO];
    op3   = w[`VBSU_OP5_HI:`VBSU_OP3_LO];
    op2   = w[`VBSU_OP5_HI:`VBSU_OP2_LO];
    k     = VBSU_K_NONE;
    if (maj == `VBSU_MAJ_COPROC) begin
      if (op5 == `VBSU_OP5_BNZV) begin
        k = VBSU_K_BNZV;
      end else if (op5 == `VBSU_OP5_BZV) begin
        k = VBSU_K_BZV;
      end else if (op3 == `VBSU_OP3_BZDF) begin
        k = VBSU_K_BZDF;
      end
    end else if (maj == `VBSU_MAJ_VECTOR) begin
      if (minor == `VBSU_MIN_VEC && op5 == `VBSU_OP5_BSELV) begin
        k = VBSU_K_BSELV;
      end else if (minor == `VBSU_MIN_IMM8 && op2 == `VBSU_OP2_BSELI) begin
        k = VBSU_K_BSELI;
      end else if (minor == `VBSU_MIN_3R_SET && op3 == `VBSU_OP3_BSET) begin
        k = VBSU_K_BSET;
      end else if (minor == `VBSU_MIN_BIT && op3 == `VBSU_OP3_BSET) begin
        k = VBSU_K_BSETI;
      end else if (minor == `VBSU_MIN_3R_CMP && op3 == `VBSU_OP3_CEQ) begin
        k = VBSU_K_CEQ;
      end
    end
    return k;
  endfunction : decodeKind

  // Registered answer and its next value.
  vbsu_state_t    state_r;
  vbsu_state_t    state_nxt;

  // Kind and fields of the word on the issue port.
  vbsu_kind_t     kind;
  vbsu_fmt_t      fmt;
  vbsu_fmt_t      immFmt;
  logic           immFmtBad;
  logic [5:0]     immPos;
  logic [6:0]     dfm;
  logic [7:0]     byteImm;

  // Element-wise results from the lane array.
  logic [127:0]   bitSetVec;
  logic [127:0]   cmpEqVec;
  logic           anyElemZero;

  // Branch address arithmetic.
  logic [31:0]    targetOffset;
  logic [31:0]    delaySlotPc;

  assign kind    = decodeKind(issueIn.insn);
  assign fmt     = vbsu_fmt_t'(issueIn.insn[`VBSU_FMT_HI:`VBSU_FMT_LO]);
  assign dfm     = issueIn.insn[`VBSU_DFM_HI:`VBSU_DFM_LO];
  assign byteImm = issueIn.insn[`VBSU_IMM8_HI:`VBSU_IMM8_LO];

  // The 7-bit field carries the format as leading ones and the position after a zero;
  // 1111xxx encodes no format and is refused as a reserved instruction.
  always_comb begin
    immFmtBad = 1'b0;
    immFmt    = VBSU_FMT_DBL;
    immPos    = dfm[5:0];
    if (!dfm[6]) begin
      // A leading zero leaves six position bits for doublewords.
      immFmt = VBSU_FMT_DBL;
      immPos = dfm[5:0];
    end else if (!dfm[5]) begin
      // Each further leading one halves the element and drops a position bit.
      immFmt = VBSU_FMT_WORD;
      immPos = {1'b0, dfm[4:0]};
    end else if (!dfm[4]) begin
      immFmt = VBSU_FMT_HALF;
      immPos = {2'b00, dfm[3:0]};
    end else if (!dfm[3]) begin
      immFmt = VBSU_FMT_BYTE;
      immPos = {3'b000, dfm[2:0]};
    end else begin
      // No format is left to decode, so the word is refused.
      immFmtBad = 1'b1;
    end
  end

  // Element-wise bit set, compare and zero test for the chosen width.
  vbsu_lane_ops u_lanes (
    .fmt         ((kind == VBSU_K_BSETI) ? immFmt : fmt),
    .useImmPos   (kind == VBSU_K_BSETI),
    .immPos      (immPos),
    .firstSrc    (opsIn.firstSrc),
    .posTest     (opsIn.posTest),
    .bitSetVec   (bitSetVec),
    .cmpEqVec    (cmpEqVec),
    .anyElemZero (anyElemZero)
  );

  // Only bits 9..0 of the word offset reach the target; its upper bits are dropped.
  assign targetOffset = {{(`VBSU_GPR_W-12){issueIn.insn[`VBSU_OFFS_SIGN]}},
                         issueIn.insn[`VBSU_OFFS_SIGN:`VBSU_OFFS_LO],
                         {`VBSU_WORD_SHIFT{1'b0}}}; // RULE_03
  // Measured from the delay slot, which the host always runs before the target.
  assign delaySlotPc  = issueIn.pc + `VBSU_INSN_BYTES; // RULE_02

  // Next answer; every field is rewritten each cycle so a result stands one cycle only.
  always_comb begin
    state_nxt                      = '0;
    state_nxt.res.destIdx          = issueIn.insn[`VBSU_DEST_HI:`VBSU_DEST_LO];
    state_nxt.res.branchTarget     = delaySlotPc + targetOffset; // RULE_03
    if (issueIn.valid && kind != VBSU_K_NONE) begin
      state_nxt.res.valid = 1'b1;
      if (!issueIn.unitEnabled) begin
        // A disabled unit writes nothing and never branches.
        state_nxt.res.excDisabled = 1'b1; // RULE_13
      end else begin
        unique case (kind)
          VBSU_K_NONE: begin
            // Unreachable behind the guard above; kept so the case stays complete.
            state_nxt.res.valid = 1'b0;
          end
          VBSU_K_BSELV: begin
            // Each old destination bit steers between the two sources.
            state_nxt.res.writeEn = 1'b1;
            state_nxt.res.data    = (opsIn.firstSrc & ~opsIn.destOld)
                                  | (opsIn.posTest & opsIn.destOld); // RULE_05
          end
          VBSU_K_BSELI: begin
            // The byte immediate repeats across all sixteen bytes.
            state_nxt.res.writeEn = 1'b1;
            state_nxt.res.data    = (opsIn.firstSrc & ~opsIn.destOld)
                                  | ({16{byteImm}} & opsIn.destOld); // RULE_06
          end
          VBSU_K_BSET: begin
            // Any position value is legal, so no operand can raise a fault.
            state_nxt.res.writeEn = 1'b1; // RULE_12
            state_nxt.res.data    = bitSetVec; // RULE_07
          end
          VBSU_K_BSETI: begin
            state_nxt.res.excReserved = immFmtBad; // RULE_13
            state_nxt.res.writeEn     = !immFmtBad;
            state_nxt.res.data        = immFmtBad ? `VBSU_RST_DATA : bitSetVec; // RULE_08
          end
          VBSU_K_CEQ: begin
            state_nxt.res.writeEn = 1'b1; // RULE_12
            state_nxt.res.data    = cmpEqVec; // RULE_11
          end
          VBSU_K_BZDF: begin
            // The lane array has already reduced the elements of the chosen width.
            state_nxt.res.branchValid = 1'b1;
            state_nxt.res.branchTaken = anyElemZero; // RULE_09
          end
          VBSU_K_BZV: begin
            // Whole-register tests ignore the format field entirely.
            state_nxt.res.branchValid = 1'b1;
            state_nxt.res.branchTaken = ~|opsIn.posTest; // RULE_10
          end
          VBSU_K_BNZV: begin
            state_nxt.res.branchValid = 1'b1;
            state_nxt.res.branchTaken = |opsIn.posTest; // RULE_01
          end
        endcase
      end
    end
  end

  // State register; the branch decision reaches the host the cycle after issue.
  // Reset clears every answer field so the host never sees a stale write or branch.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r                  <= '0;
      state_r.res.data         <= `VBSU_RST_DATA;
      state_r.res.branchTarget <= `VBSU_RST_ADDR;
      state_r.res.destIdx      <= `VBSU_RST_IDX;
    end else begin
      state_r <= state_nxt; // RULE_03
    end
  end

  assign resultOut = state_r.res;

endmodule : vbsu_unit
`default_nettype wire

// ### shared/vbsu_params.svh
`ifndef VBSU_PARAMS_SVH
`define VBSU_PARAMS_SVH

// Datapath widths.
`define VBSU_VEC_W        128
`define VBSU_GPR_W        32
`define VBSU_INSN_W       32

// Major and minor opcode values.
`define VBSU_MAJ_VECTOR   6'h1e
`define VBSU_MAJ_COPROC   6'h11
`define VBSU_MIN_VEC      6'h1e
`define VBSU_MIN_IMM8     6'h01
`define VBSU_MIN_3R_SET   6'h0d
`define VBSU_MIN_3R_CMP   6'h0f
`define VBSU_MIN_BIT      6'h09

// Sub-opcode values in bits 25..21, 25..23 and 25..24.
`define VBSU_OP5_BNZV     5'h0f
`define VBSU_OP5_BZV      5'h0b
`define VBSU_OP5_BSELV    5'h06
`define VBSU_OP3_BSET     3'h4
`define VBSU_OP3_BZDF     3'h6
`define VBSU_OP3_CEQ      3'h0
`define VBSU_OP2_BSELI    2'h2

// Instruction field positions.
`define VBSU_MAJ_HI       31
`define VBSU_MAJ_LO       26
`define VBSU_OP5_HI       25
`define VBSU_OP5_LO       21
`define VBSU_OP3_LO       23
`define VBSU_OP2_LO       24
`define VBSU_FMT_HI       22
`define VBSU_FMT_LO       21
`define VBSU_DEST_HI      10
`define VBSU_DEST_LO      6
`define VBSU_MIN_HI       5
`define VBSU_MIN_LO       0
`define VBSU_IMM8_HI      23
`define VBSU_IMM8_LO      16
`define VBSU_DFM_HI       22
`define VBSU_DFM_LO       16
`define VBSU_OFFS_SIGN    9
`define VBSU_OFFS_LO      0

// Branch arithmetic.
`define VBSU_INSN_BYTES   32'h00000004
`define VBSU_WORD_SHIFT   2

// Reset values.
`define VBSU_RST_DATA     128'h0
`define VBSU_RST_ADDR     32'h00000000
`define VBSU_RST_IDX      5'h00

`endif

// ### shared/vbsu_pkg.sv
package vbsu_pkg;

  // Element format.
  typedef enum logic [1:0] {
    VBSU_FMT_BYTE = 2'b00,
    VBSU_FMT_HALF = 2'b01,
    VBSU_FMT_WORD = 2'b10,
    VBSU_FMT_DBL  = 2'b11
  } vbsu_fmt_t;

  // Decoded instruction kind.
  typedef enum logic [3:0] {
    VBSU_K_NONE  = 4'b0000,
    VBSU_K_BSELV = 4'b0001,
    VBSU_K_BSELI = 4'b0010,
    VBSU_K_BSET  = 4'b0011,
    VBSU_K_BSETI = 4'b0100,
    VBSU_K_CEQ   = 4'b0101,
    VBSU_K_BZDF  = 4'b0110,
    VBSU_K_BZV   = 4'b0111,
    VBSU_K_BNZV  = 4'b1000
  } vbsu_kind_t;

  // Issue from the host pipeline.
  typedef struct packed {
    logic        valid;
    logic [31:0] insn;
    logic [31:0] pc;
    logic        unitEnabled;
  } vbsu_issue_t;

  // Operand vectors read from the vector register file.
  typedef struct packed {
    logic [127:0] firstSrc;
    logic [127:0] posTest;
    logic [127:0] destOld;
  } vbsu_operands_t;

  // Answer to the host pipeline.
  typedef struct packed {
    logic         valid;
    logic         writeEn;
    logic [4:0]   destIdx;
    logic [127:0] data;
    logic         branchValid;
    logic         branchTaken;
    logic [31:0]  branchTarget;
    logic         excReserved;
    logic         excDisabled;
  } vbsu_result_t;

  // Whole state of the top module.
  typedef struct packed {
    vbsu_result_t res;
  } vbsu_state_t;

endpackage : vbsu_pkg

// ### tb/vbsu_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module vbsu_host_model
  import vbsu_pkg::*;
(
  // Clock.
  input  wire logic           clk,
  // Issue side.
  output var  vbsu_issue_t    issueIn,
  output var  vbsu_operands_t opsIn,
  // Answer side.
  input  wire vbsu_result_t   resultOut
);
  vbsu_result_t got;
  // Nothing is issued until the first call.
  initial begin
    issueIn = '0;
    opsIn = '0;
  end
  // One instruction per call with one idle cycle between calls, so no branch lands in a delay slot.
  task automatic xfer(input logic [31:0] insn, input logic [127:0] firstSrc, posTest, destOld,
                      input logic en);
    @(negedge clk);
    issueIn = '{1'b1, insn, 32'h00001000, en};
    opsIn = '{firstSrc, posTest, destOld};
    @(negedge clk);
    got = resultOut;
    // Released lines other than the enable carry the inverse, so a stale value cannot pass.
    issueIn = '{1'b0, ~insn, 32'hffffefff, en};
    opsIn = ~opsIn;
  endtask : xfer
endmodule : vbsu_host_model
`default_nettype wire

// ### tb/vbsu_unit_sva.sv
`timescale 1ns/1ps
`default_nettype none
module vbsu_unit_sva
  import vbsu_pkg::*;
(
  // Clock and reset.
  input wire logic           clk,
  input wire logic           rstn,
  // Watched ports.
  input wire vbsu_issue_t    issueIn,
  input wire vbsu_operands_t opsIn,
  input wire vbsu_result_t   resultOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [31:0]  in;
  logic [31:0]  tgt;
  logic [127:0] sel;
  logic [127:0] seli;
  logic         en;
  logic         cop;
  logic         vec;
  logic         bzv;
  logic         bnzv;
  logic         br;
  logic         bsel;
  logic         bseli;
  logic         ceq;
  logic         tz;
  // Decode of the issue, kept apart from the design so a decode slip shows.
  assign in = issueIn.insn;
  assign en = issueIn.unitEnabled;
  assign cop = issueIn.valid && in[31:26] == 6'h11;
  assign vec = issueIn.valid && in[31:26] == 6'h1e;
  assign bzv = cop && in[25:21] == 5'h0b;
  assign bnzv = cop && in[25:21] == 5'h0f;
  assign br = bzv || bnzv || (cop && in[25:23] == 3'h6);
  assign bsel = vec && in[25:21] == 5'h06 && in[5:0] == 6'h1e;
  assign bseli = vec && in[25:24] == 2'h2 && in[5:0] == 6'h01;
  assign ceq = vec && in[25:23] == 3'h0 && in[5:0] == 6'h0f;
  assign tz = opsIn.posTest == '0;
  assign tgt = issueIn.pc + 32'h4 + {{20{in[9]}}, in[9:0], 2'b00};
  assign sel = (opsIn.firstSrc & ~opsIn.destOld) | (opsIn.posTest & opsIn.destOld);
  assign seli = (opsIn.firstSrc & ~opsIn.destOld) | ({16{in[23:16]}} & opsIn.destOld);

  // A data answer: written, no branch decision beside it.
  sequence s_written;
    resultOut.valid && resultOut.writeEn && !resultOut.branchValid;
  endsequence
  property p_bsel;
    bsel && en |=> s_written ##0 resultOut.data == $past(sel);
  endproperty
  property p_bseli;
    bseli && en |=> s_written ##0 resultOut.data == $past(seli);
  endproperty
  property p_ceq;
    ceq && en && opsIn.firstSrc == opsIn.posTest |=> s_written ##0 resultOut.data == '1;
  endproperty
  property p_noexc;
    ceq && en |=> !resultOut.excReserved && !resultOut.excDisabled;
  endproperty
  property p_bzv;
    bzv && en |=> resultOut.branchValid && resultOut.branchTaken == $past(tz);
  endproperty
  property p_bnzv;
    bnzv && en |=> resultOut.branchValid && resultOut.branchTaken == !$past(tz);
  endproperty
  property p_tgt;
    br && en |=> resultOut.branchTarget == $past(tgt);
  endproperty
  property p_off;
    !en && (br || bsel) |=> resultOut.excDisabled && !resultOut.writeEn && !resultOut.branchValid;
  endproperty
  a_bsel: assert property (p_bsel) else $error("bit select data wrong");
  a_bseli: assert property (p_bseli) else $error("immediate select data wrong");
  a_ceq: assert property (p_ceq) else $error("equal compare not all ones");
  a_noexc: assert property (p_noexc) else $error("compare raised exception");
  a_bzv: assert property (p_bzv) else $error("zero branch decision wrong");
  a_bnzv: assert property (p_bnzv) else $error("nonzero branch decision wrong");
  a_tgt: assert property (p_tgt) else $error("branch target wrong");
  a_off: assert property (p_off) else $error("disabled answer wrong");
endmodule : vbsu_unit_sva

bind vbsu_unit vbsu_unit_sva u_sva (.clk(clk), .rstn(rstn), .issueIn(issueIn), .opsIn(opsIn),
  .resultOut(resultOut));
`default_nettype wire

// ### tb/vector_bitselect_branch_unit_test.sv
`timescale 1ns/1ps
`default_nettype none
module vector_bitselect_branch_unit_test
  import vbsu_pkg::*;
;
  localparam logic [127:0] VA = {4{32'h0f1e2d3c}};
  localparam logic [127:0] VB = {4{32'hc3d2e1f0}};
  localparam logic [127:0] VM = {4{32'hff00a5a5}};
  logic           clk;
  logic           rstn;
  vbsu_issue_t    issueIn;
  vbsu_operands_t opsIn;
  vbsu_result_t   resultOut;
  int             error_cnt;
  int             samples_checked;
  int             cycles;

  vbsu_unit dut (.clk(clk), .rstn(rstn), .issueIn(issueIn), .opsIn(opsIn), .resultOut(resultOut));
  vbsu_host_model host (.clk(clk), .issueIn(issueIn), .opsIn(opsIn), .resultOut(resultOut));

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  task automatic t_select;
    host.xfer({6'h1e, 5'h06, 10'h0, 5'd3, 6'h1e}, VA, VB, VM, 1'b1);
    chk(host.got.data, (VA & ~VM) | (VB & VM));
    chk({host.got.valid, host.got.writeEn, host.got.branchValid, host.got.destIdx}, 8'hc3);
    host.xfer({6'h1e, 2'h2, 8'ha5, 5'd0, 5'd4, 6'h01}, VA, VB, VM, 1'b1);
    chk(host.got.data, (VA & ~VM) | ({16{8'ha5}} & VM));
  endtask : t_select

  // High position bits are set on purpose; only the low ones may count.
  task automatic t_bitset;
    host.xfer({6'h1e, 3'h4, 2'h0, 10'h0, 5'd5, 6'h0d}, VB, {16{8'hfa}}, VM, 1'b1);
    chk(host.got.data, VB | {16{8'h04}});
    host.xfer({6'h1e, 3'h4, 2'h3, 10'h0, 5'd5, 6'h0d}, VB, {2{64'h43}}, VM, 1'b1);
    chk(host.got.data, VB | {2{64'h08}});
    host.xfer({6'h1e, 3'h4, 7'h21, 5'd0, 5'd6, 6'h09}, VB, VA, VM, 1'b1);
    chk(host.got.data, VB | {2{64'h200000000}});
    host.xfer({6'h1e, 3'h4, 7'h73, 5'd0, 5'd6, 6'h09}, VB, VA, VM, 1'b1);
    chk(host.got.data, VB | {16{8'h08}});
    host.xfer({6'h1e, 3'h4, 7'h7c, 5'd0, 5'd6, 6'h09}, VB, VA, VM, 1'b1);
    chk({host.got.valid, host.got.excReserved, host.got.writeEn}, 3'b110);
    chk(host.got.data, 128'h0);
  endtask : t_bitset

  // Only the lowest byte differs, so the format decides how much is cleared.
  task automatic t_compare;
    host.xfer({6'h1e, 3'h0, 2'h0, 10'h0, 5'd7, 6'h0f}, VA, VA ^ 128'h1, VM, 1'b1);
    chk(host.got.data, {{15{8'hff}}, 8'h00});
    host.xfer({6'h1e, 3'h0, 2'h2, 10'h0, 5'd7, 6'h0f}, VA, VA ^ 128'h1, VM, 1'b1);
    chk(host.got.data, {{3{32'hffffffff}}, 32'h0});
    chk(host.got.excReserved, 1'b0);
    host.xfer({6'h1e, 3'h0, 2'h3, 10'h0, 5'd7, 6'h0f}, VB, VB, VM, 1'b1);
    chk(host.got.data, {128{1'b1}});
  endtask : t_compare

  task automatic br(input logic [31:0] insn, input logic [127:0] testVec, input logic [33:0] exp);
    host.xfer(insn, VA, testVec, VM, 1'b1);
    chk({host.got.branchValid, host.got.branchTaken, host.got.branchTarget}, exp);
  endtask : br

  task automatic t_branch;
    br({6'h11, 5'h0b, 5'd0, 16'h03ff}, '0, {2'b11, 32'h1000});
    br({6'h11, 5'h0b, 5'd0, 16'h03ff}, 128'h1, {2'b10, 32'h1000});
    br({6'h11, 5'h0f, 5'd0, 16'h0010}, {1'b1, 127'h0}, {2'b11, 32'h1044});
    br({6'h11, 5'h0f, 5'd0, 16'h0010}, '0, {2'b10, 32'h1044});
    br({6'h11, 3'h6, 2'h0, 5'd0, 16'h0200}, {VA[127:8], 8'h0}, {2'b11, 32'h0804});
    br({6'h11, 3'h6, 2'h2, 5'd0, 16'h0001}, {VA[127:8], 8'h0}, {2'b10, 32'h1008});
  endtask : t_branch

  task automatic t_disabled;
    host.xfer({6'h1e, 5'h06, 10'h0, 5'd3, 6'h1e}, VA, VB, VM, 1'b0);
    chk({host.got.valid, host.got.excDisabled, host.got.writeEn, host.got.branchValid},
        4'b1100);
    host.xfer({6'h11, 5'h0b, 5'd0, 16'h0001}, VA, VB, VM, 1'b0);
    chk({host.got.valid, host.got.excDisabled, host.got.branchValid}, 3'b110);
    // A neighbouring instruction under the same opcode must draw no answer at all.
    host.xfer({6'h1e, 5'h05, 10'h0, 5'd3, 6'h1e}, VA, VB, VM, 1'b1);
    chk({host.got.valid, host.got.writeEn, host.got.branchValid, host.got.excReserved,
         host.got.excDisabled}, 5'h00);
  endtask : t_disabled

  // Free-running clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // The whole run needs well under a hundred cycles; this cuts a hang short.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      error_cnt++;
      summarize();
    end
  end

  // Main sequence.
  initial begin
    rstn = 1'b0;
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    t_select();
    t_bitset();
    t_compare();
    t_branch();
    t_disabled();
    summarize();
  end
endmodule : vector_bitselect_branch_unit_test
`default_nettype wire
